//--- aro_consts.vh
// Register map, field positions, reset values and timing constants of the aux input / relay select block
`ifndef ARO_CONSTS_VH
`define ARO_CONSTS_VH

// Register byte offsets
`define ARO_ADDR_RELAY_SEL 8'h00
`define ARO_ADDR_AUX_SEL 8'h04
`define ARO_ADDR_CTRL 8'h08
`define ARO_ADDR_MIN_FREQ 8'h0c
`define ARO_ADDR_STATUS 8'h10
`define ARO_ADDR_INT_STATUS 8'h14
`define ARO_ADDR_INT_MASK 8'h18
`define ARO_ADDR_OP_STATE 8'h1c

// Relay selector fields (3 bits each) in RELAY_SEL
`define ARO_RLY1_LSB 0
`define ARO_RLY2_LSB 4
`define ARO_RLY3_LSB 8
`define ARO_RLY4_LSB 12
// Aux selector fields (3 bits each) in AUX_SEL
`define ARO_AUX_INPUT_ONE_LSB 0
`define ARO_AUX_INPUT_TWO_LSB 4
// CTRL bits
`define ARO_CTRL_LOCKOUT 0
`define ARO_CTRL_LEADLAG 1
`define ARO_CTRL_SYSCFG 2

// Reset values
`define ARO_RELAY_SEL_RST 16'h0000
`define ARO_AUX_SEL_RST 8'h00
`define ARO_CTRL_RST 3'h0
`define ARO_MIN_FREQ_RST 16'h0000
`define ARO_INT_MASK_RST 5'h00
`define ARO_OP_STATE_RST 2'h0

// Relay selector codes
`define ARO_RSEL_SYS_FAULT 3'h0
`define ARO_RSEL_PUMP_FAULT 3'h4
`define ARO_RSEL_MIN_FREQ 3'h5
`define ARO_RSEL_JOCKEY 3'h6

// Aux selector codes
`define ARO_ASEL_RUN_STOP 3'h0
`define ARO_ASEL_ALWAYS_RUN 3'h1
`define ARO_ASEL_LATCH_OPEN 3'h2
`define ARO_ASEL_DISABLED 3'h3
`define ARO_ASEL_LATCH_CLOSE 3'h4
`define ARO_ASEL_FAULT_RESET 3'h5

// Operating states
`define ARO_OP_OFF 2'h0
`define ARO_OP_AUTO 2'h1
`define ARO_OP_MANUAL 2'h2

// Interrupt status bits
`define ARO_INT_AUX_INPUT_ONE_LATCH 0
`define ARO_INT_AUX_INPUT_TWO_LATCH 1
`define ARO_INT_FAULT_RESET 2
`define ARO_INT_MANUAL_REJ 3
`define ARO_INT_DRIVE_FAULT 4

// Timing
`define ARO_CLK_MHZ 20
`define ARO_DEBOUNCE_US 1000
`define ARO_DEBOUNCE_CYCLES (`ARO_DEBOUNCE_US * `ARO_CLK_MHZ)

`endif

//--- aro_io_select.v
// Aux contact input functions, relay output selection, manual lockout and register port
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "aro_consts.vh"
// How it works
// [R1] Relay selector 0: relay follows drive fault, changing state when the drive faults.
// [R2] Selector 4: relay follows pump faults only; codes 1 to 3 leave relay idle.
// [R3] Selector 5: relay on while motor frequency strictly exceeds minimum frequency.
// [R4] Lead/lag enabled: all four relays follow pump control, selectors ignored.
// [R5] Relay two drives both normally-open and normally-closed contacts.
// [R6] Relay three has open contact only, same selector codes as relay two.
// [R7] Relay four has open contact only, same selector codes as relay two.
// [R8] Manual lockout rejects keypad manual mode; only auto and off allowed.
// [R9] Aux selector 0: contact closed runs, open stops.
// [R10] Aux selector 1: permanent run request whatever the contact.
// [R11] Aux selector 2: contact opening stops motor and latches a displayed fault.
// [R12] Aux selector 4: contact closing stops motor and latches a displayed fault.
// [R13] Latched aux fault clears only on an enter key press.
// [R14] Aux one selector 3 disables the input function.
// [R15] Aux selector 5: input turning on clears the active drive fault.
// [R16] Fault reset is edge triggered; an input already on must cycle off then on.
// [R17] System configuration override forces both aux inputs to run/stop use.
// [R18] Aux contacts are synchronised and debounced before use.
module aro_io_select #(
  parameter DEBOUNCE_CYCLES = `ARO_DEBOUNCE_CYCLES,
  parameter CNT_W = 16,
  parameter FREQ_W = 16
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Drive status and keypad
  input wire drive_fault_in,
  input wire pump_fault_in,
  input wire [FREQ_W-1:0] motor_freq_in,
  input wire enter_key_in,
  input wire keypad_mode_req_in,
  input wire [1:0] keypad_mode_in,
  input wire [3:0] leadlag_relay_in,
  // Dry contacts, high while closed
  input wire aux_input_one_in,
  input wire aux_input_two_in,
  // Relay drives
  output reg relay_one_out,
  output reg relay_two_open_contact_out,
  output reg relay_two_closed_contact_out,
  output reg relay_three_open_contact_out,
  output reg relay_four_open_contact_out,
  // Drive commands and status
  output reg motor_run_out,
  output reg fault_reset_out,
  output reg aux_fault_out,
  output reg [1:0] op_state_out,
  output reg irq_out
);

  // Last count of the debounce window, cut to the counter width on purpose
  localparam integer DB_LAST_I = DEBOUNCE_CYCLES - 1;
  localparam [CNT_W-1:0] DB_LAST = DB_LAST_I[CNT_W-1:0];

  // Relay condition for one selector; jockey mode only where allowed
  function relay_cond;
    input [2:0] sel;
    input allow_jockey;
    input drive_fault;
    input pump_fault;
    input above_min;
    input above_zero;
    begin
      case (sel)
        `ARO_RSEL_SYS_FAULT: relay_cond = drive_fault; // see [R1]
        `ARO_RSEL_PUMP_FAULT: relay_cond = pump_fault; // see [R2]
        `ARO_RSEL_MIN_FREQ: relay_cond = above_min; // see [R3]
        `ARO_RSEL_JOCKEY: relay_cond = allow_jockey & above_zero;
        default: relay_cond = 1'b0; // see [R2]
      endcase
    end
  endfunction

  // Run permission of one aux input for its selector
  function aux_run;
    input [2:0] sel;
    input level;
    input latched;
    begin
      case (sel)
        `ARO_ASEL_RUN_STOP: aux_run = level; // see [R9]
        `ARO_ASEL_ALWAYS_RUN: aux_run = 1'b1; // see [R10]
        `ARO_ASEL_LATCH_OPEN: aux_run = ~latched; // see [R11]
        `ARO_ASEL_LATCH_CLOSE: aux_run = ~latched; // see [R12]
        default: aux_run = 1'b1; // see [R14]
      endcase
    end
  endfunction

  // Configuration registers
  reg [15:0] relay_sel_q;
  reg [7:0] aux_sel_q;
  reg [2:0] ctrl_q;
  reg [FREQ_W-1:0] min_freq_q;
  reg [4:0] int_mask_q;
  reg [4:0] int_status_q;
  reg [4:0] int_status_d;

  // Input conditioning state
  reg [1:0] sync1_q;
  reg [1:0] sync2_q;
  reg [1:0] stable_q;
  reg [1:0] stable_prev_q;
  reg [CNT_W-1:0] db_cnt_q [0:1];
  reg drive_fault_q;
  reg [FREQ_W-1:0] freq_q;

  // Function state
  reg [1:0] latch_q;
  reg [1:0] latch_d;
  reg [2:0] aux_input_one_sel;
  reg [2:0] aux_input_two_sel;
  reg [1:0] op_state_d;
  reg manual_rej;
  reg reset_edge;
  reg run_d;
  reg [4:0] events;
  reg above_min;
  reg above_zero;
  reg [3:0] relay_d;
  integer i;

  // Write decode, shared by all register writes
  wire wr_relay = reg_wr_in && (reg_addr_in == `ARO_ADDR_RELAY_SEL);
  wire wr_aux = reg_wr_in && (reg_addr_in == `ARO_ADDR_AUX_SEL);
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `ARO_ADDR_CTRL);
  wire wr_minf = reg_wr_in && (reg_addr_in == `ARO_ADDR_MIN_FREQ);
  wire wr_int = reg_wr_in && (reg_addr_in == `ARO_ADDR_INT_STATUS);
  wire wr_mask = reg_wr_in && (reg_addr_in == `ARO_ADDR_INT_MASK);
  wire wr_op = reg_wr_in && (reg_addr_in == `ARO_ADDR_OP_STATE);

  // Configuration registers, written by software
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      relay_sel_q <= `ARO_RELAY_SEL_RST;
      aux_sel_q <= `ARO_AUX_SEL_RST;
      ctrl_q <= `ARO_CTRL_RST;
      min_freq_q <= `ARO_MIN_FREQ_RST;
      int_mask_q <= `ARO_INT_MASK_RST;
    end else begin
      if (wr_relay) begin
        relay_sel_q <= reg_wdata_in[15:0];
      end
      if (wr_aux) begin
        aux_sel_q <= reg_wdata_in[7:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in[2:0];
      end
      if (wr_minf) begin
        min_freq_q <= reg_wdata_in[FREQ_W-1:0];
      end
      if (wr_mask) begin
        int_mask_q <= reg_wdata_in[4:0];
      end
    end
  end

  // Two-flop synchronisers; the first flop feeds only the second
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {aux_input_two_in, aux_input_one_in}; // see [R18]
      sync2_q <= sync1_q;
    end
  end

  // Debounce: a level must hold for the whole window before it is taken,
  // which delays every aux function by that time but rejects contact bounce
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stable_q <= 2'h0;
      stable_prev_q <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
        db_cnt_q[i] <= {CNT_W{1'b0}};
      end
    end else begin
      stable_prev_q <= stable_q;
      for (i = 0; i < 2; i = i + 1) begin
        if (sync2_q[i] == stable_q[i]) begin
          db_cnt_q[i] <= {CNT_W{1'b0}};
        end else if (db_cnt_q[i] == DB_LAST) begin
          stable_q[i] <= sync2_q[i]; // see [R18]
          db_cnt_q[i] <= {CNT_W{1'b0}};
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  // Drive fault and motor frequency are taken from same-clock logic, registered once for timing
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_fault_q <= 1'b0;
      freq_q <= {FREQ_W{1'b0}};
    end else begin
      drive_fault_q <= drive_fault_in;
      freq_q <= motor_freq_in;
    end
  end

  // Effective aux selectors, latches and fault reset
  always @* begin
    aux_input_one_sel = aux_sel_q[`ARO_AUX_INPUT_ONE_LSB +: 3];
    aux_input_two_sel = aux_sel_q[`ARO_AUX_INPUT_TWO_LSB +: 3];
    if (ctrl_q[`ARO_CTRL_SYSCFG]) begin
      aux_input_one_sel = `ARO_ASEL_RUN_STOP; // see [R17]
      aux_input_two_sel = `ARO_ASEL_RUN_STOP; // see [R17]
    end
    latch_d = latch_q;
    if (enter_key_in) begin
      latch_d = 2'h0; // see [R13]
    end
    // Set wins over the enter key so a still-active contact keeps the fault
    if ((aux_input_one_sel == `ARO_ASEL_LATCH_OPEN) && !stable_q[0]) begin
      latch_d[0] = 1'b1; // see [R11]
    end
    if ((aux_input_one_sel == `ARO_ASEL_LATCH_CLOSE) && stable_q[0]) begin
      latch_d[0] = 1'b1; // see [R12]
    end
    if ((aux_input_two_sel == `ARO_ASEL_LATCH_OPEN) && !stable_q[1]) begin
      latch_d[1] = 1'b1; // see [R11]
    end
    if ((aux_input_two_sel == `ARO_ASEL_LATCH_CLOSE) && stable_q[1]) begin
      latch_d[1] = 1'b1; // see [R12]
    end
    // Only a rising edge resets, so an input held on through a fault does nothing
    reset_edge = drive_fault_q && (
      ((aux_input_one_sel == `ARO_ASEL_FAULT_RESET) && stable_q[0] && !stable_prev_q[0]) ||
      ((aux_input_two_sel == `ARO_ASEL_FAULT_RESET) && stable_q[1] && !stable_prev_q[1])); // see [R15] see [R16]
  end

  // Operating state with manual lockout
  always @* begin
    op_state_d = op_state_out;
    manual_rej = 1'b0;
    if (keypad_mode_req_in || wr_op) begin
      if (keypad_mode_req_in) begin
        op_state_d = keypad_mode_in;
      end else begin
        op_state_d = reg_wdata_in[1:0];
      end
      if (op_state_d == `ARO_OP_MANUAL && ctrl_q[`ARO_CTRL_LOCKOUT]) begin
        op_state_d = op_state_out; // see [R8]
        manual_rej = 1'b1;
      end else if (op_state_d != `ARO_OP_AUTO && op_state_d != `ARO_OP_MANUAL) begin
        op_state_d = `ARO_OP_OFF;
      end
    end
    // Turning the lockout on while in manual falls back to off
    if (ctrl_q[`ARO_CTRL_LOCKOUT] && op_state_d == `ARO_OP_MANUAL) begin
      op_state_d = `ARO_OP_OFF; // see [R8]
    end
  end

  // Run command; a latched aux fault stops the motor in every state
  always @* begin
    case (op_state_out)
      `ARO_OP_AUTO: run_d = aux_run(aux_input_one_sel, stable_q[0], latch_d[0]) & aux_run(aux_input_two_sel, stable_q[1], latch_d[1]);
      `ARO_OP_MANUAL: run_d = ~(|latch_d);
      default: run_d = 1'b0;
    endcase
    run_d = run_d & ~(|latch_d); // see [R11] see [R12]
  end

  // Relay conditions
  always @* begin
    above_min = freq_q > min_freq_q; // see [R3]
    above_zero = freq_q != {FREQ_W{1'b0}};
    relay_d[0] = relay_cond(relay_sel_q[`ARO_RLY1_LSB +: 3], 1'b1, drive_fault_q, pump_fault_in,
      above_min, above_zero);
    relay_d[1] = relay_cond(relay_sel_q[`ARO_RLY2_LSB +: 3], 1'b0, drive_fault_q, pump_fault_in,
      above_min, above_zero);
    relay_d[2] = relay_cond(relay_sel_q[`ARO_RLY3_LSB +: 3], 1'b0, drive_fault_q, pump_fault_in,
      above_min, above_zero); // see [R6]
    relay_d[3] = relay_cond(relay_sel_q[`ARO_RLY4_LSB +: 3], 1'b0, drive_fault_q, pump_fault_in,
      above_min, above_zero); // see [R7]
    if (ctrl_q[`ARO_CTRL_LEADLAG]) begin
      relay_d = leadlag_relay_in; // see [R4]
    end
  end

  // Interrupt events and sticky status; a new event beats a write-one clear
  always @* begin
    events = 5'h00;
    events[`ARO_INT_AUX_INPUT_ONE_LATCH] = latch_d[0] & ~latch_q[0];
    events[`ARO_INT_AUX_INPUT_TWO_LATCH] = latch_d[1] & ~latch_q[1];
    events[`ARO_INT_FAULT_RESET] = reset_edge;
    events[`ARO_INT_MANUAL_REJ] = manual_rej;
    events[`ARO_INT_DRIVE_FAULT] = drive_fault_in & ~drive_fault_q;
    int_status_d = int_status_q;
    if (wr_int) begin
      int_status_d = int_status_q & ~reg_wdata_in[4:0];
    end
    int_status_d = int_status_d | events;
  end

  // Function state and registered outputs
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_q <= 2'h0;
      int_status_q <= 5'h00;
      irq_out <= 1'b0;
      motor_run_out <= 1'b0;
      fault_reset_out <= 1'b0;
      aux_fault_out <= 1'b0;
      op_state_out <= `ARO_OP_STATE_RST;
      relay_one_out <= 1'b0;
      relay_two_open_contact_out <= 1'b0;
      relay_two_closed_contact_out <= 1'b1;
      relay_three_open_contact_out <= 1'b0;
      relay_four_open_contact_out <= 1'b0;
    end else begin
      latch_q <= latch_d;
      int_status_q <= int_status_d;
      irq_out <= |(int_status_d & int_mask_q);
      motor_run_out <= run_d;
      fault_reset_out <= reset_edge; // see [R15]
      aux_fault_out <= |latch_d; // see [R11] see [R12]
      op_state_out <= op_state_d;
      relay_one_out <= relay_d[0];
      relay_two_open_contact_out <= relay_d[1]; // see [R5]
      relay_two_closed_contact_out <= ~relay_d[1]; // see [R5]
      relay_three_open_contact_out <= relay_d[2]; // see [R6]
      relay_four_open_contact_out <= relay_d[3]; // see [R7]
    end
  end

  // Read data stands only in the cycle after the read strobe; unmapped reads zero
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ARO_ADDR_RELAY_SEL: reg_rdata_out <= {16'h0000, relay_sel_q};
        `ARO_ADDR_AUX_SEL: reg_rdata_out <= {24'h00_0000, aux_sel_q};
        `ARO_ADDR_CTRL: reg_rdata_out <= {29'h0000_0000, ctrl_q};
        `ARO_ADDR_MIN_FREQ: reg_rdata_out <= {{(32-FREQ_W){1'b0}}, min_freq_q};
        `ARO_ADDR_STATUS: reg_rdata_out <= {20'h0_0000, stable_q, latch_q, motor_run_out, drive_fault_q,
          relay_four_open_contact_out, relay_three_open_contact_out, relay_two_open_contact_out, relay_one_out,
          op_state_out};
        `ARO_ADDR_INT_STATUS: reg_rdata_out <= {27'h000_0000, int_status_q};
        `ARO_ADDR_INT_MASK: reg_rdata_out <= {27'h000_0000, int_mask_q};
        `ARO_ADDR_OP_STATE: reg_rdata_out <= {30'h0000_0000, op_state_out};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

//--- aro_io_select_properties.sv
// Concurrent checks on the aux input and relay select ports
`timescale 1ns/1ns
`default_nettype none
module aro_io_select_properties #(
  parameter FREQ_W = 16
) (
  // Watched inputs
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic drive_fault_in,
  input wire logic pump_fault_in,
  input wire logic [FREQ_W-1:0] motor_freq_in,
  input wire logic enter_key_in,
  input wire logic [3:0] leadlag_relay_in,
  // Watched outputs
  input wire logic relay_one_out,
  input wire logic relay_two_open_contact_out,
  input wire logic relay_two_closed_contact_out,
  input wire logic relay_three_open_contact_out,
  input wire logic relay_four_open_contact_out,
  input wire logic fault_reset_out,
  input wire logic aux_fault_out,
  input wire logic [1:0] op_state_out
);
  logic [15:0] rsel_q;
  logic [2:0] ctrl_q;
  logic [FREQ_W-1:0] minf_q;
  logic [1:0] quiet_q;
  logic df1_q, df2_q, pf_q, gt1_q, gt2_q;
  wire cfg_wr = reg_wr_in && (reg_addr_in == 8'h00 || reg_addr_in == 8'h08 || reg_addr_in == 8'h0c);
  wire ok = quiet_q == 2'h3 && !ctrl_q[1];
  // Shadow config; checks wait three edges after a config write so pipelines refill
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsel_q <= 16'h0000;
      ctrl_q <= 3'h0;
      minf_q <= '0;
      quiet_q <= 2'h0;
      {df1_q, df2_q, pf_q, gt1_q, gt2_q} <= 5'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h00) rsel_q <= reg_wdata_in[15:0];
      if (reg_wr_in && reg_addr_in == 8'h08) ctrl_q <= reg_wdata_in[2:0];
      if (reg_wr_in && reg_addr_in == 8'h0c) minf_q <= reg_wdata_in[FREQ_W-1:0];
      quiet_q <= cfg_wr ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
      {df1_q, df2_q, pf_q, gt1_q, gt2_q} <= {drive_fault_in, df1_q, pump_fault_in, motor_freq_in > minf_q, gt1_q};
    end
  end
  // Expected relay level for one selector code
  function automatic logic rx(input logic [2:0] s, input logic d, input logic p, input logic g);
    rx = s == 3'h0 ? d : s == 3'h4 ? p : s == 3'h5 ? g : 1'b0;
  endfunction
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_relay_one_sel: assert property (ok && rsel_q[2:0] != 3'h6 |->
    relay_one_out == rx(rsel_q[2:0], df2_q, pf_q, gt2_q))
    else $error("relay one level wrong");
  chk_relay_two_sel: assert property (ok |->
    relay_two_open_contact_out == rx(rsel_q[6:4], df2_q, pf_q, gt2_q))
    else $error("relay two level wrong");
  chk_relay_three_sel: assert property (ok |->
    relay_three_open_contact_out == rx(rsel_q[10:8], df2_q, pf_q, gt2_q))
    else $error("relay three level wrong");
  chk_relay_four_sel: assert property (ok |->
    relay_four_open_contact_out == rx(rsel_q[14:12], df2_q, pf_q, gt2_q))
    else $error("relay four level wrong");
  chk_two_contacts: assert property (relay_two_closed_contact_out != relay_two_open_contact_out)
    else $error("relay two contacts not complementary");
  chk_leadlag_pass: assert property (quiet_q == 2'h3 && ctrl_q[1] |-> {relay_four_open_contact_out,
    relay_three_open_contact_out, relay_two_open_contact_out, relay_one_out} == $past(leadlag_relay_in))
    else $error("pump control not passed to relays");
  chk_no_manual: assert property (quiet_q == 2'h3 && ctrl_q[0] |-> op_state_out != 2'h2)
    else $error("manual state under lockout");
  chk_enter_clear: assert property ($fell(aux_fault_out) |->
    $past(enter_key_in) || $past(enter_key_in, 2))
    else $error("aux fault cleared without enter");
  chk_reset_pulse: assert property (fault_reset_out |=> !fault_reset_out)
    else $error("fault reset longer than one cycle");
endmodule
bind aro_io_select aro_io_select_properties #(.FREQ_W(FREQ_W)) aro_io_select_properties_inst (.sys_clk_in, .rst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .drive_fault_in, .pump_fault_in, .motor_freq_in, .enter_key_in,
  .leadlag_relay_in, .relay_one_out, .relay_two_open_contact_out, .relay_two_closed_contact_out,
  .relay_three_open_contact_out, .relay_four_open_contact_out, .fault_reset_out, .aux_fault_out, .op_state_out);
`default_nettype wire

//--- aro_contacts.sv
// Dry contact model with contact bounce on every change
`timescale 1ns/1ns
`default_nettype none
module aro_contacts (
  // Wanted contact states, 1 = closed
  input wire logic [1:0] want_in,
  // Contact levels seen by the drive
  output logic [1:0] aux_out
);
  logic [1:0] chg;
  initial aux_out = 2'b00;
  // Changed contacts chatter three times, well inside the debounce time
  always @(want_in) begin
    chg = want_in ^ aux_out;
    repeat (3) begin
      #13 aux_out = aux_out ^ chg;
    end
  end
endmodule
`default_nettype wire

//--- aro_io_select_tb.sv
// Self-checking bench for the aux input and relay select block
`timescale 1ns/1ns
`default_nettype none
module aro_io_select_tb;
  logic sys_clk_in = 0, rst_in = 1, wr = 0, rd = 0, df = 0, pf = 0, ek = 0, kreq = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, seed = 32'h0001_0eb0;
  logic [15:0] freq = 16'h0000;
  logic [1:0] kmode = 2'h0, want = 2'h0;
  logic [3:0] ll = 4'h0, exv;
  logic ex, pdf, pgt, lt;
  wire [31:0] rdata;
  wire [1:0] aux, ops;
  wire r1, r2o, r2c, r3, r4, run, frst, afault, irq;
  int err_count = 0, tests_run = 0, npulse = 0;
  aro_io_select #(.DEBOUNCE_CYCLES(4)) aro_io_select_inst (.sys_clk_in, .rst_in, .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .drive_fault_in(df),
    .pump_fault_in(pf), .motor_freq_in(freq), .enter_key_in(ek), .keypad_mode_req_in(kreq),
    .keypad_mode_in(kmode), .leadlag_relay_in(ll), .aux_input_one_in(aux[0]), .aux_input_two_in(aux[1]),
    .relay_one_out(r1), .relay_two_open_contact_out(r2o), .relay_two_closed_contact_out(r2c),
    .relay_three_open_contact_out(r3), .relay_four_open_contact_out(r4), .motor_run_out(run),
    .fault_reset_out(frst), .aux_fault_out(afault), .op_state_out(ops), .irq_out(irq));
  aro_contacts aro_contacts_inst (.want_in(want), .aux_out(aux));
  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // Each fault reset pulse stands one cycle, so it is counted once
  always @(posedge sys_clk_in) npulse += (frst === 1'b1);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  // Run request of one aux input for its selector
  function automatic logic ar(input logic [2:0] s, input logic lv, input logic l);
    ar = s == 3'h0 ? lv : (s == 3'h2 || s == 3'h4) ? !l : 1'b1;
  endfunction
  // A latch selector is active on an open contact (2) or a closed one (4)
  function automatic logic act(input logic [2:0] s, input logic l);
    act = (s == 3'h2 && !l) || (s == 3'h4 && l);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Bus cycles end 1 ns after the edge so strobes never toggle twice in a step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge sys_clk_in);
    wr <= 0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1;
    @(posedge sys_clk_in);
    rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic kp(input logic [1:0] m);
    kmode <= m;
    kreq <= 1;
    @(posedge sys_clk_in);
    kreq <= 0;
    #1;
  endtask
  // Aux step: the new selector sees the old contact level first, and the enter press
  // lands before the new level is debounced, so an old active level beats the press
  task automatic step(input logic [2:0] s1, input logic [2:0] s2, input logic [1:0] w, input logic e);
    if (act(s1, want[0])) lt = 1;
    else if (e) lt = 0;
    if (act(s1, w[0])) lt = 1;
    wreg(8'h04, {25'h000_0000, s2, 1'b0, s1});
    want <= w;
    ek <= e;
    @(posedge sys_clk_in);
    ek <= 0;
    cyc(16);
    chk("aux_fault", lt, afault);
    chk("run", ar(s1, w[0], lt) & ar(s2, w[1], 1'b0), run);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    test_done;
  end
  initial begin
    cyc(8);
    chk("relay_two_closed", 1, r2c);
    rst_in <= 0;
    cyc(1);
    for (int a = 0; a < 9; a++) rreg(a * 4, 0);
    // Relay codes 0 to 5, then pump control, against random drive status
    wreg(8'h0c, 32'h0000_8000);
    for (int c = 0; c < 7; c++) begin
      wreg(8'h00, {16'h0000, {4{1'b0, c[2:0]}}});
      wreg(8'h08, c == 6 ? 32'h0000_0002 : 32'h0000_0000);
      for (int i = 0; i < 24; i++) begin
        seed = xs(seed);
        {df, pf, ll} <= seed[5:0];
        freq <= seed[31:16];
        @(posedge sys_clk_in);
        ex = c == 0 ? pdf : c == 4 ? pf : c == 5 ? pgt : 1'b0;
        exv = c == 6 ? ll : {4{ex}};
        pdf = df;
        pgt = freq > 16'h8000;
        #1;
        if (i > 2) chk("relays", {exv, ~exv[1]}, {r4, r3, r2o, r1, r2c});
      end
    end
    wreg(8'h08, 32'h0000_0000);
    df <= 0;
    // Manual lockout with its interrupt
    wreg(8'h14, 32'h0000_001f);
    wreg(8'h18, 32'h0000_0008);
    kp(2'h2);
    cyc(2);
    chk("op_state", 2, ops);
    wreg(8'h08, 32'h0000_0001);
    cyc(3);
    chk("op_state", 0, ops);
    kp(2'h1);
    kp(2'h2);
    cyc(2);
    chk("op_state", 1, ops);
    chk("irq", 1, irq);
    rreg(8'h14, 32'h0000_0008);
    wreg(8'h14, 32'h0000_0008);
    cyc(2);
    chk("irq", 0, irq);
    wreg(8'h08, 32'h0000_0000);
    // Aux functions in auto state
    lt = 0;
    step(0, 0, 2'b11, 0);
    step(0, 0, 2'b10, 0);
    step(1, 1, 2'b00, 0);
    step(3, 1, 2'b00, 0);
    step(2, 1, 2'b01, 0);
    step(2, 1, 2'b00, 0);
    step(2, 1, 2'b01, 0);
    step(2, 1, 2'b01, 1);
    step(4, 1, 2'b01, 0);
    step(4, 1, 2'b01, 1);
    step(4, 1, 2'b00, 0);
    step(4, 1, 2'b00, 1);
    // Override makes both inputs run/stop; left with both open so no latch follows
    wreg(8'h08, 32'h0000_0004);
    want <= 2'b11;
    cyc(16);
    chk("run", 1, run);
    want <= 2'b00;
    cyc(16);
    chk("run", 0, run);
    wreg(8'h08, 32'h0000_0000);
    step(5, 1, 2'b01, 0);
    // Fault arriving with the reset input already on needs a fresh edge
    npulse = 0;
    df <= 1;
    cyc(12);
    chk("pulses", 0, npulse);
    want <= 2'b00;
    cyc(16);
    want <= 2'b01;
    cyc(16);
    chk("pulses", 1, npulse);
    test_done;
  end
endmodule
`default_nettype wire
